/* File: core/ipr_pkg.sv */
// Package for the interrupt priority register bank (registers eight to thirteen).
// Assumes a 32-bit AXI4-Lite master and one synchronous active-high reset.
package ipr_pkg;

	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned REG_W     = 16;
	localparam int unsigned LVL_W     = 3;
	localparam int unsigned NUM_REGS  = 6;
	localparam int unsigned NUM_SRC   = 23;
	localparam int unsigned IDX_W     = 3;
	localparam int unsigned IDX_LSB   = 2;
	localparam int unsigned IDX_REG11 = 3;

	// Byte offsets of the registers
	localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_8  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_9  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_10 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_11 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_12 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PRIO_CTRL_13 = 8'h14;

	// Field positions
	localparam int unsigned FLD_HI   = 12;
	localparam int unsigned FLD_MH   = 8;
	localparam int unsigned FLD_ML   = 4;
	localparam int unsigned FLD_LO   = 0;

	// Implemented bits and reset values
	localparam logic [REG_W-1:0] MASK_FULL   = 16'h7777;
	localparam logic [REG_W-1:0] MASK_REG11  = 16'h7707;
	localparam logic [REG_W-1:0] RESET_PAT   = 16'h4444;
	localparam logic [LVL_W-1:0] LVL_DISABLED = 3'h0;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [LVL_W-1:0] ipr_level_t;
	typedef logic [REG_W-1:0] ipr_word_t;

	// Current level of every source, in source order
	typedef struct packed {
		ipr_level_t can_one_event_level;
		ipr_level_t can_one_rx_level;
		ipr_level_t serial_periph_two_event_level;
		ipr_level_t serial_periph_two_error_level;
		ipr_level_t capture_five_level;
		ipr_level_t capture_four_level;
		ipr_level_t capture_three_level;
		ipr_level_t dma_three_done_level;
		ipr_level_t compare_seven_level;
		ipr_level_t compare_six_level;
		ipr_level_t compare_five_level;
		ipr_level_t capture_six_level;
		ipr_level_t timer_six_level;
		ipr_level_t dma_four_done_level;
		ipr_level_t compare_eight_level;
		ipr_level_t timer_eight_level;
		ipr_level_t twowire_two_master_level;
		ipr_level_t twowire_two_slave_level;
		ipr_level_t timer_seven_level;
		ipr_level_t can_two_rx_level;
		ipr_level_t ext_irq_four_level;
		ipr_level_t ext_irq_three_level;
		ipr_level_t timer_nine_level;
	} ipr_levels_s;

endpackage

/* File: core/ipr_prio_regs.sv */
// Interrupt priority register bank eight to thirteen with an AXI4-Lite slave.
// Assumes AXI4-Lite master on clk_i; arbitration logic reads the level outputs.
`timescale 1ns/1ps

// Function
// RQ1: Field 111 means level seven, highest
// RQ2: Field 001 is level one, linear
// RQ3: Field 000 disables source, never requested
// RQ4: Unimplemented bits always read zero
// RQ5: Fields reset to 100, level four
// RQ6: Register eight holds CAN one, serial fields
// RQ7: Register nine holds captures five-three, DMA three
// RQ8: Register ten holds compares seven-five, capture six
// RQ9: Register eleven: timer six, DMA four, compare eight
// RQ10: Register twelve: timers eight, seven, two-wire
// RQ11: Register thirteen: CAN two, externals, timer nine
// RQ12: Bits 15, 11, 7, 3 read zero
// RQ13: Unimplemented writes ignored; levels driven continuously
// RQ14: Enabled sources need a nonzero level
module ipr_prio_regs
(
	input  wire logic                         clk_i,
	input  wire logic                         reset_i,
	input  wire logic [ipr_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
	input  wire logic                         s_axi_awvalid_i,
	output logic                              s_axi_awready_o,
	input  wire logic [ipr_pkg::DATA_W-1:0]   s_axi_wdata_i,
	input  wire logic [3:0]                   s_axi_wstrb_i,
	input  wire logic                         s_axi_wvalid_i,
	output logic                              s_axi_wready_o,
	output logic [1:0]                        s_axi_bresp_o,
	output logic                              s_axi_bvalid_o,
	input  wire logic                         s_axi_bready_i,
	input  wire logic [ipr_pkg::ADDR_W-1:0]   s_axi_araddr_i,
	input  wire logic                         s_axi_arvalid_i,
	output logic                              s_axi_arready_o,
	output logic [ipr_pkg::DATA_W-1:0]        s_axi_rdata_o,
	output logic [1:0]                        s_axi_rresp_o,
	output logic                              s_axi_rvalid_o,
	input  wire logic                         s_axi_rready_i,
	input  wire logic [ipr_pkg::NUM_SRC-1:0]  src_flag_i,
	output ipr_pkg::ipr_levels_s              levels_o,
	output logic [ipr_pkg::NUM_SRC-1:0]       src_request_o
);

	// Implemented bits of one register
	function automatic ipr_pkg::ipr_word_t reg_mask(input int unsigned idx);
		reg_mask = (idx == ipr_pkg::IDX_REG11) ? ipr_pkg::MASK_REG11 : ipr_pkg::MASK_FULL; // [RQ9] [RQ12]
	endfunction

	// Check that a byte address falls on one of the six registers
	function automatic logic addr_hit(input logic [ipr_pkg::ADDR_W-1:0] a);
		logic [ipr_pkg::IDX_W-1:0] i;
		i = a[ipr_pkg::IDX_LSB +: ipr_pkg::IDX_W];
		addr_hit = (a[ipr_pkg::ADDR_W-1:ipr_pkg::IDX_LSB+ipr_pkg::IDX_W] == '0)
			&& (int'(i) < ipr_pkg::NUM_REGS);
	endfunction

	// Index bits of a byte address
	function automatic logic [ipr_pkg::IDX_W-1:0] addr_idx(input logic [ipr_pkg::ADDR_W-1:0] a);
		addr_idx = a[ipr_pkg::IDX_LSB +: ipr_pkg::IDX_W];
	endfunction

	// Priority registers and their next values
	ipr_pkg::ipr_word_t            prio_reg  [ipr_pkg::NUM_REGS];
	ipr_pkg::ipr_word_t            prio_next [ipr_pkg::NUM_REGS];

	// Write channel holding state
	logic [ipr_pkg::ADDR_W-1:0]    awaddr_reg;
	logic [ipr_pkg::ADDR_W-1:0]    awaddr_next;
	logic [ipr_pkg::DATA_W-1:0]    wdata_reg;
	logic [ipr_pkg::DATA_W-1:0]    wdata_next;
	logic [3:0]                    wstrb_reg;
	logic [3:0]                    wstrb_next;
	logic                          aw_held_reg;
	logic                          aw_held_next;
	logic                          w_held_reg;
	logic                          w_held_next;
	logic                          awready_reg;
	logic                          awready_next;
	logic                          wready_reg;
	logic                          wready_next;
	logic                          bvalid_reg;
	logic                          bvalid_next;
	logic [1:0]                    bresp_reg;
	logic [1:0]                    bresp_next;
	// Read channel state
	logic                          arready_reg;
	logic                          arready_next;
	logic                          rvalid_reg;
	logic                          rvalid_next;
	logic [1:0]                    rresp_reg;
	logic [1:0]                    rresp_next;
	logic [ipr_pkg::DATA_W-1:0]    rdata_reg;
	logic [ipr_pkg::DATA_W-1:0]    rdata_next;
	// Request stage and field view
	logic [ipr_pkg::NUM_SRC-1:0]   request_reg;
	logic [ipr_pkg::NUM_SRC-1:0]   request_next;
	ipr_pkg::ipr_levels_s          lv;
	logic [ipr_pkg::NUM_SRC*ipr_pkg::LVL_W-1:0] lv_flat;

	// Write channel and register update
	always_comb
	begin
		logic                       aw_take;
		logic                       w_take;
		logic                       have_aw;
		logic                       have_w;
		logic [ipr_pkg::ADDR_W-1:0] wa;
		logic [ipr_pkg::DATA_W-1:0] wd;
		logic [3:0]                 ws;
		ipr_pkg::ipr_word_t         be;
		aw_take = s_axi_awvalid_i && awready_reg;
		w_take  = s_axi_wvalid_i && wready_reg;
		have_aw = aw_held_reg || aw_take;
		have_w  = w_held_reg || w_take;
		wa      = aw_held_reg ? awaddr_reg : s_axi_awaddr_i;
		wd      = w_held_reg ? wdata_reg : s_axi_wdata_i;
		ws      = w_held_reg ? wstrb_reg : s_axi_wstrb_i;
		be      = {{8{ws[1]}}, {8{ws[0]}}};
		awaddr_next  = aw_take ? s_axi_awaddr_i : awaddr_reg;
		wdata_next   = w_take ? s_axi_wdata_i : wdata_reg;
		wstrb_next   = w_take ? s_axi_wstrb_i : wstrb_reg;
		aw_held_next = have_aw;
		w_held_next  = have_w;
		bvalid_next  = bvalid_reg && !s_axi_bready_i;
		bresp_next   = bresp_reg;
		for (int r = 0; r < ipr_pkg::NUM_REGS; r++)
		begin
			prio_next[r] = prio_reg[r];
		end
		if (have_aw && have_w && !bvalid_reg)
		begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = ipr_pkg::RESP_SLVERR;
			if (addr_hit(wa))
			begin
				bresp_next = ipr_pkg::RESP_OKAY;
				for (int r = 0; r < ipr_pkg::NUM_REGS; r++)
				begin
					if (addr_idx(wa) == r[ipr_pkg::IDX_W-1:0])
					begin
						prio_next[r] = ((prio_reg[r] & ~be) | (wd[ipr_pkg::REG_W-1:0] & be))
							& reg_mask(r); // [RQ13] [RQ4]
					end
				end
			end
		end
		awready_next = !aw_held_next && !bvalid_next;
		wready_next  = !w_held_next && !bvalid_next;
	end

	// Write side registers
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			for (int r = 0; r < ipr_pkg::NUM_REGS; r++)
			begin
				prio_reg[r] <= ipr_pkg::RESET_PAT & reg_mask(r); // [RQ5]
			end
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= ipr_pkg::RESP_OKAY;
		end
		else
		begin
			for (int r = 0; r < ipr_pkg::NUM_REGS; r++)
			begin
				prio_reg[r] <= prio_next[r];
			end
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	// Read channel
	always_comb
	begin
		logic ar_take;
		ar_take     = s_axi_arvalid_i && arready_reg;
		rvalid_next = rvalid_reg && !s_axi_rready_i;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (ar_take)
		begin
			rvalid_next = 1'b1;
			rdata_next  = '0;
			rresp_next  = ipr_pkg::RESP_SLVERR;
			if (addr_hit(s_axi_araddr_i))
			begin
				rresp_next = ipr_pkg::RESP_OKAY;
				for (int r = 0; r < ipr_pkg::NUM_REGS; r++)
				begin
					if (addr_idx(s_axi_araddr_i) == r[ipr_pkg::IDX_W-1:0])
					begin
						rdata_next = {16'h0000, prio_reg[r] & reg_mask(r)}; // [RQ4] [RQ12]
					end
				end
			end
		end
		arready_next = !rvalid_next;
	end

	// Read side registers
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= ipr_pkg::RESP_OKAY;
			rdata_reg   <= '0;
		end
		else
		begin
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Field map of the six registers
	always_comb
	begin
		lv.can_one_event_level           = prio_reg[0][ipr_pkg::FLD_HI +: ipr_pkg::LVL_W]; // [RQ6]
		lv.can_one_rx_level              = prio_reg[0][ipr_pkg::FLD_MH +: ipr_pkg::LVL_W]; // [RQ6]
		lv.serial_periph_two_event_level = prio_reg[0][ipr_pkg::FLD_ML +: ipr_pkg::LVL_W]; // [RQ6]
		lv.serial_periph_two_error_level = prio_reg[0][ipr_pkg::FLD_LO +: ipr_pkg::LVL_W]; // [RQ6]
		lv.capture_five_level            = prio_reg[1][ipr_pkg::FLD_HI +: ipr_pkg::LVL_W]; // [RQ7]
		lv.capture_four_level            = prio_reg[1][ipr_pkg::FLD_MH +: ipr_pkg::LVL_W]; // [RQ7]
		lv.capture_three_level           = prio_reg[1][ipr_pkg::FLD_ML +: ipr_pkg::LVL_W]; // [RQ7]
		lv.dma_three_done_level          = prio_reg[1][ipr_pkg::FLD_LO +: ipr_pkg::LVL_W]; // [RQ7]
		lv.compare_seven_level           = prio_reg[2][ipr_pkg::FLD_HI +: ipr_pkg::LVL_W]; // [RQ8]
		lv.compare_six_level             = prio_reg[2][ipr_pkg::FLD_MH +: ipr_pkg::LVL_W]; // [RQ8]
		lv.compare_five_level            = prio_reg[2][ipr_pkg::FLD_ML +: ipr_pkg::LVL_W]; // [RQ8]
		lv.capture_six_level             = prio_reg[2][ipr_pkg::FLD_LO +: ipr_pkg::LVL_W]; // [RQ8]
		lv.timer_six_level               = prio_reg[3][ipr_pkg::FLD_HI +: ipr_pkg::LVL_W]; // [RQ9]
		lv.dma_four_done_level           = prio_reg[3][ipr_pkg::FLD_MH +: ipr_pkg::LVL_W]; // [RQ9]
		lv.compare_eight_level           = prio_reg[3][ipr_pkg::FLD_LO +: ipr_pkg::LVL_W]; // [RQ9]
		lv.timer_eight_level             = prio_reg[4][ipr_pkg::FLD_HI +: ipr_pkg::LVL_W]; // [RQ10]
		lv.twowire_two_master_level      = prio_reg[4][ipr_pkg::FLD_MH +: ipr_pkg::LVL_W]; // [RQ10]
		lv.twowire_two_slave_level       = prio_reg[4][ipr_pkg::FLD_ML +: ipr_pkg::LVL_W]; // [RQ10]
		lv.timer_seven_level             = prio_reg[4][ipr_pkg::FLD_LO +: ipr_pkg::LVL_W]; // [RQ10]
		lv.can_two_rx_level              = prio_reg[5][ipr_pkg::FLD_HI +: ipr_pkg::LVL_W]; // [RQ11]
		lv.ext_irq_four_level            = prio_reg[5][ipr_pkg::FLD_MH +: ipr_pkg::LVL_W]; // [RQ11]
		lv.ext_irq_three_level           = prio_reg[5][ipr_pkg::FLD_ML +: ipr_pkg::LVL_W]; // [RQ11]
		lv.timer_nine_level              = prio_reg[5][ipr_pkg::FLD_LO +: ipr_pkg::LVL_W]; // [RQ11]
	end

	// Flat view for per-source gating
	assign lv_flat = lv;

	// Request gating per source, bit i pairs with field i counted from the top
	generate
		for (genvar s = 0; s < ipr_pkg::NUM_SRC; s++)
		begin : g_req
			localparam int unsigned POS = (ipr_pkg::NUM_SRC - 1 - s) * ipr_pkg::LVL_W;
			assign request_next[s] = src_flag_i[s]
				&& (lv_flat[POS +: ipr_pkg::LVL_W] != ipr_pkg::LVL_DISABLED); // [RQ3] [RQ1] [RQ2]
		end
	endgenerate

	// Request register
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			request_reg <= '0;
		end
		else
		begin
			request_reg <= request_next;
		end
	end

	// Outputs straight from registers
	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o  = wready_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign levels_o        = lv; // [RQ13]
	assign src_request_o   = request_reg;

endmodule

/* File: test/ipr_prio_regs_monitor.sv */
// Port checker for the priority register bank.
// Assumes one clock and a bind onto ipr_prio_regs.
`timescale 1ns/1ps
module ipr_prio_regs_monitor
(
	input wire logic	clk_i,
	input wire logic	reset_i,
	input wire logic [7:0]	s_axi_awaddr_i,
	input wire logic	s_axi_awvalid_i,
	input wire logic	s_axi_awready_o,
	input wire logic [31:0]	s_axi_wdata_i,
	input wire logic [3:0]	s_axi_wstrb_i,
	input wire logic	s_axi_wvalid_i,
	input wire logic	s_axi_wready_o,
	input wire logic [1:0]	s_axi_bresp_o,
	input wire logic	s_axi_bvalid_o,
	input wire logic	s_axi_bready_i,
	input wire logic [7:0]	s_axi_araddr_i,
	input wire logic	s_axi_arvalid_i,
	input wire logic	s_axi_arready_o,
	input wire logic [31:0]	s_axi_rdata_o,
	input wire logic [1:0]	s_axi_rresp_o,
	input wire logic	s_axi_rvalid_o,
	input wire logic	s_axi_rready_i,
	input wire logic [22:0]	src_flag_i,
	input wire ipr_pkg::ipr_levels_s	levels_o,
	input wire logic [22:0]	src_request_o
);
	logic [22:0]	lvl_on;
	logic	rd_bad;
	always_comb
	begin
		for (int s = 0; s < 23; s++)
			lvl_on[s] = |levels_o[68-3*s -: 3];
	end
	assign rd_bad = (s_axi_araddr_i[7:5] != 3'h0) || (s_axi_araddr_i[4:2] > 3'h5);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_req_gated: assert property (!$past(reset_i) |->
		src_request_o == $past(src_flag_i & lvl_on)) else $error("request not gated by level");
	a_read_zero: assert property (s_axi_rvalid_o |->
		(s_axi_rdata_o & 32'hFFFF8888) == 32'h0) else $error("unused bits read nonzero");
	a_reset_lvls: assert property ($past(reset_i) |->
		levels_o == {23{3'h4}}) else $error("levels not four after reset");
	a_lvl_by_write: assert property (!$past(reset_i) && !$stable(levels_o) |->
		$rose(s_axi_bvalid_o)) else $error("levels changed without a write");
	a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |=> s_axi_bvalid_o && !s_axi_awready_o) else $error("no write answer");
	a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
		&& s_axi_rresp_o == ($past(rd_bad) ? 2'h2 : 2'h0)) else $error("bad read answer");
	a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
		!s_axi_bvalid_o ##[0:1] s_axi_awready_o) else $error("write channel not freed");
	a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
		!s_axi_rvalid_o ##[0:1] s_axi_arready_o) else $error("read channel not freed");
	c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
	c_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
	c_off: cover property (|(src_flag_i & ~lvl_on));
endmodule

bind ipr_prio_regs ipr_prio_regs_monitor u_mon (.*);

/* File: test/tb_ipr_prio_regs.sv */
// Self-checking bench for the priority register bank.
// Assumes ipr_pkg and the bound checker compiled first.
`timescale 1ns/1ps
module tb_ipr_prio_regs;
	logic	clk_i = 1'b0;
	logic	reset_i = 1'b1;
	logic [7:0]	s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	logic [31:0]	s_axi_wdata_i = '0, s_axi_rdata_o;
	logic [3:0]	s_axi_wstrb_i = '0;
	logic [1:0]	s_axi_bresp_o, s_axi_rresp_o;
	logic	s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic	s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic	s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [22:0]	src_flag_i = '0, src_request_o;
	ipr_pkg::ipr_levels_s	levels_o;
	logic [15:0]	mdl [6];
	int	num_errors = 0;
	int	checks_done = 0;
	ipr_prio_regs dut (.*);
	always #2.5 clk_i = ~clk_i;
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [68:0] seen, input logic [68:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	function automatic logic bad(input logic [7:0] a);
		return a[7:5] != 3'h0 || a[4:2] > 3'h5;
	endfunction
	function automatic logic [15:0] msk(input int r);
		return r == 3 ? ipr_pkg::MASK_REG11 : ipr_pkg::MASK_FULL;
	endfunction
	function automatic logic [68:0] exp_lv();
		logic [68:0] v;
		v = '0;
		for (int r = 0; r < 6; r++)
			for (int f = 12; f >= 0; f -= 4)
				if (r != 3 || f != 4)
					v = {v[65:0], mdl[r][f+:3]};
		return v;
	endfunction
	function automatic logic [22:0] exp_req(input logic [22:0] fl);
		logic [68:0] v;
		logic [22:0] q;
		v = exp_lv();
		for (int s = 0; s < 23; s++)
			q[s] = fl[s] && v[68-3*s -: 3] != 3'h0;
		return q;
	endfunction
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_arvalid_i && s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end
		while (!s_axi_rvalid_o);
		d = s_axi_rdata_o;
		rs = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic op(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] m;
		logic [31:0] q;
		logic [1:0] rs;
		logic [22:0] fl;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= s;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awvalid_i && s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end
		while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
		chk(s_axi_bresp_o, bad(a) ? 2'h2 : 2'h0);
		m = {{8{s[1]}}, {8{s[0]}}} & msk(a[4:2]);
		if (!bad(a))
			mdl[a[4:2]] = (mdl[a[4:2]] & ~m) | (d[15:0] & m);
		chk(levels_o, exp_lv());
		rd(a, q, rs);
		chk(q, bad(a) ? 32'h0 : {16'h0, mdl[a[4:2]]});
		chk(rs, bad(a) ? 2'h2 : 2'h0);
		fl = 23'($urandom);
		src_flag_i <= fl;
		repeat (2) @(posedge clk_i);
		chk(src_request_o, exp_req(fl));
	endtask
	initial
	begin
		logic [31:0] q;
		logic [1:0] rs;
		void'($urandom(32'h52cc));
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int r = 0; r < 6; r++)
			mdl[r] = 16'h4444 & msk(r);
		chk(levels_o, {23{3'h4}});
		for (int r = 0; r < 6; r++)
		begin
			rd(8'(r * 4), q, rs);
			chk(q, {16'h0, 16'h4444 & msk(r)});
		end
		for (int c = 0; c < 8; c++)
			for (int r = 0; r < 6; r++)
				op(8'(r * 4), {16'hFFFF, {4{1'b1, 3'(c)}}}, 4'hF);
		op(8'h10, 32'h0000_2100, 4'h1);
		op(8'h10, 32'h0000_5600, 4'h2);
		op(8'h18, 32'h0000_1111, 4'hF);
		repeat (60)
			op({3'($urandom_range(0, 9) == 0), 3'($urandom), 2'h0}, $urandom, 4'($urandom));
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int r = 0; r < 6; r++)
			mdl[r] = 16'h4444 & msk(r);
		chk(levels_o, {23{3'h4}});
		op(8'h0C, 32'h0, 4'hF);
		complete_run();
	end
	initial
	begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule
